// ### hdl/sru_pkg.sv
package sru_pkg;

  // Register word indices on the Avalon bus; byte address is four times these
  localparam logic [15:0] IDX_BREAK_EXIT    = 16'hFE00;
  localparam logic [15:0] IDX_RESET_CAUSE   = 16'hFE01;
  localparam logic [15:0] IDX_BREAK_CLR_CTL = 16'hFE03;
  localparam logic [15:0] IDX_OPTION        = 16'hFE04;
  localparam logic [15:0] IDX_IRQ_STATUS    = 16'hFE05;
  localparam logic [15:0] IDX_IRQ_MASK      = 16'hFE06;

  // Break exit status layout
  localparam int BIT_BREAK_WAIT_EXIT = 1;

  // Reset cause layout
  localparam int BIT_POWER_ON      = 7;
  localparam int BIT_PIN_CAUSE     = 6;
  localparam int BIT_WATCHDOG      = 5;
  localparam int BIT_BAD_OPCODE    = 4;
  localparam int BIT_BAD_FETCH     = 3;
  localparam int BIT_MONITOR_ENTRY = 2;
  localparam int BIT_LOW_VOLTAGE   = 1;

  // Break flag clear control layout
  localparam int BIT_BREAK_CLR_EN = 7;

  // Option register layout
  localparam int BIT_FAST_RECOVERY = 0;
  localparam int BIT_OSC_IN_STOP   = 1;

  // Interrupt status and mask layout
  localparam int BIT_EV_STOP_ENTER = 0;
  localparam int BIT_EV_STOP_DONE  = 1;
  localparam int BIT_EV_RESET_SEEN = 2;
  localparam int BIT_EV_BREAK_WAIT = 3;
  localparam int NUM_EVENTS        = 4;

  // Reset values
  localparam logic [7:0] RST_RESET_CAUSE = 8'h80;
  localparam logic [7:0] RST_BREAK_EXIT  = 8'h00;
  localparam logic [7:0] RST_BREAK_CTL   = 8'h00;
  localparam logic [7:0] RST_OPTION      = 8'h00;
  localparam logic [3:0] RST_IRQ         = 4'h0;

  // Stop recovery delays in crystal clock cycles
  localparam int SLOW_RECOVERY_CYC = 4096;
  localparam int FAST_RECOVERY_CYC = 32;
  localparam int RECOVERY_CNT_W    = 13;

  typedef enum logic [1:0] {
    SRU_RUN,
    SRU_STOPPED,
    SRU_RECOVER
  } sru_state_t;

endpackage : sru_pkg

// ### hdl/sru_system_integration_unit.sv
// Notes on behaviour
// [R01] Stop entry resets the system counter and switches off every system clock.
// [R02] An interrupt request ends stop; stacking starts only after the full recovery delay.
// [R03] Every reset source forces the device out of stop mode.
// [R04] In stop, bus clock output and crystal clock output are both gated off.
// [R05] Recovery lasts 4096 crystal cycles, or 32 when fast recovery is selected.
// [R06] With an external crystal keep fast recovery off unless oscillator runs in stop.
// [R07] Counter held at zero from stop entry until recovery, then times recovery.
// [R08] Break status, reset cause, break clear control sit at FE00, FE01, FE03.
// [R09] Break status holds one flag, meaningful only in emulation mode.
// [R10] Break exit flag is one when a break ended wait, otherwise zero.
// [R11] Reading the reset cause register clears all of its flags.
// [R12] Power-on reset sets the power-on flag and clears all other cause flags.
// [R13] Other reset sources set their own flag and leave the rest untouched.
// [R14] Separate flags: pin, watchdog, bad opcode, bad fetch address, low voltage.
// [R15] Monitor entry flag set when vectors read FF and interrupt pin not at test level.
// [R16] Break clear enable set lets other modules clear flags during break; clear forbids.
// [R17] Flags cleared in break stay cleared; two-step clears finish after break.
// [R18] Reset cause read returns the flags as they stood before the clear.
//
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
module sru_system_integration_unit #(
  parameter int SLOW_CYC = sru_pkg::SLOW_RECOVERY_CYC,
  parameter int FAST_CYC = sru_pkg::FAST_RECOVERY_CYC
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [15:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        stop_req,
  input  wire logic        wait_req,
  input  wire logic        module_irq,
  input  wire logic        break_irq,
  input  wire logic        emulation_mode,
  input  wire logic        break_state,
  input  wire logic        pin_reset_evt,
  input  wire logic        watchdog_evt,
  input  wire logic        bad_opcode_evt,
  input  wire logic        bad_fetch_evt,
  input  wire logic        low_voltage_evt,
  input  wire logic        monitor_entry_evt,
  input  wire logic        vectors_read_ff,
  input  wire logic        test_level_voltage,
  output logic             clockgen_bus_output_en,
  output logic             clockgen_crystal_clock_en,
  output logic             stop_active,
  output logic             counter_hold,
  output logic             stacking_start,
  output logic             wait_wake,
  output logic             status_clear_allowed,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  sru_pkg::sru_state_t                       state_r, state_nxt;
  logic [sru_pkg::RECOVERY_CNT_W-1:0]        cnt_r, cnt_nxt;
  logic                                      in_wait_r, in_wait_nxt;
  logic [7:0]                                brk_exit_r, brk_exit_nxt;
  logic [7:0]                                cause_r, cause_nxt;
  logic [7:0]                                brk_ctl_r, brk_ctl_nxt;
  logic [7:0]                                option_r, option_nxt;
  logic [sru_pkg::NUM_EVENTS-1:0]            ists_r, ists_nxt;
  logic [sru_pkg::NUM_EVENTS-1:0]            imask_r, imask_nxt;
  logic                                      done_r, done_nxt;
  logic [31:0]                               rdata_r, rdata_nxt;
  logic                                      stack_r, stack_nxt;
  logic                                      wake_r, wake_nxt;

  logic                                      req;
  logic                                      accept;
  logic                                      wr_acc;
  logic                                      rd_acc;
  logic                                      any_reset_evt;
  logic                                      monitor_hit;
  logic [sru_pkg::RECOVERY_CNT_W-1:0]        delay_last;
  logic [sru_pkg::NUM_EVENTS-1:0]            ev;
  logic [7:0]                                cause_set;

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: one wait cycle, then the answer

  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~done_r;
  assign accept          = req & done_r;
  assign wr_acc          = avs_write & done_r;
  assign rd_acc          = avs_read & done_r;
  assign avs_readdata    = rdata_r;

  // Reset sources other than power-on, including the monitor entry condition
  assign monitor_hit   = monitor_entry_evt & vectors_read_ff & ~test_level_voltage; // [R15]
  assign any_reset_evt = pin_reset_evt | watchdog_evt | bad_opcode_evt
                       | bad_fetch_evt | low_voltage_evt | monitor_hit;

  // Selected recovery length, last count value
  assign delay_last = option_r[sru_pkg::BIT_FAST_RECOVERY]
                    ? sru_pkg::RECOVERY_CNT_W'(FAST_CYC - 1)
                    : sru_pkg::RECOVERY_CNT_W'(SLOW_CYC - 1); // [R05]

  // One bit per reset source, never touching the power-on flag
  always_comb begin
    cause_set                             = 8'h00;
    cause_set[sru_pkg::BIT_PIN_CAUSE]     = pin_reset_evt;   // [R14]
    cause_set[sru_pkg::BIT_WATCHDOG]      = watchdog_evt;    // [R14]
    cause_set[sru_pkg::BIT_BAD_OPCODE]    = bad_opcode_evt;  // [R14]
    cause_set[sru_pkg::BIT_BAD_FETCH]     = bad_fetch_evt;   // [R14]
    cause_set[sru_pkg::BIT_LOW_VOLTAGE]   = low_voltage_evt; // [R14]
    cause_set[sru_pkg::BIT_MONITOR_ENTRY] = monitor_hit;     // [R15]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stop and wait sequencing

  always_comb begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    in_wait_nxt = in_wait_r;
    stack_nxt   = 1'b0;
    wake_nxt    = 1'b0;
    ev          = '0;
    case (state_r)
      sru_pkg::SRU_RUN: begin
        cnt_nxt = cnt_r + 1'b1;
        if (stop_req && !any_reset_evt) begin
          state_nxt                        = sru_pkg::SRU_STOPPED; // [R01]
          cnt_nxt                          = '0;                   // [R01]
          ev[sru_pkg::BIT_EV_STOP_ENTER]   = 1'b1;
        end
      end
      sru_pkg::SRU_STOPPED: begin
        cnt_nxt = '0; // [R07]
        if (any_reset_evt) begin
          state_nxt = sru_pkg::SRU_RUN; // [R03]
        end else if (module_irq) begin
          state_nxt = sru_pkg::SRU_RECOVER; // [R02]
        end
      end
      sru_pkg::SRU_RECOVER: begin
        cnt_nxt = cnt_r + 1'b1; // [R07]
        if (any_reset_evt) begin
          state_nxt = sru_pkg::SRU_RUN; // [R03]
          cnt_nxt   = '0;
        end else if (cnt_r == delay_last) begin
          // Stacking only once the whole delay has run out
          state_nxt                       = sru_pkg::SRU_RUN; // [R02]
          stack_nxt                       = 1'b1;             // [R02]
          ev[sru_pkg::BIT_EV_STOP_DONE]   = 1'b1;
        end
      end
      default: begin
        state_nxt = sru_pkg::SRU_RUN;
        cnt_nxt   = '0;
      end
    endcase
    // Wait mode tracking; clocks to peripherals keep running meanwhile
    if (wait_req && state_r == sru_pkg::SRU_RUN) begin
      in_wait_nxt = 1'b1;
    end
    if (in_wait_r && (module_irq || break_irq || any_reset_evt)) begin
      in_wait_nxt = 1'b0;
      wake_nxt    = 1'b1;
    end
    ev[sru_pkg::BIT_EV_RESET_SEEN] = any_reset_evt;
    ev[sru_pkg::BIT_EV_BREAK_WAIT] = in_wait_r & break_irq & emulation_mode;
  end

  // Clock gates follow the stop state so the gating never glitches mid-cycle
  assign stop_active               = (state_r != sru_pkg::SRU_RUN);
  assign clockgen_bus_output_en    = ~stop_active; // [R04]
  assign clockgen_crystal_clock_en = ~stop_active; // [R04]
  assign counter_hold              = (state_r == sru_pkg::SRU_STOPPED); // [R07]
  assign stacking_start            = stack_r;
  assign wait_wake                 = wake_r;

  // Other modules may clear their flags in break only when enabled;
  // outside break their own clear sequences run untouched
  assign status_clear_allowed = ~break_state
                              | brk_ctl_r[sru_pkg::BIT_BREAK_CLR_EN]; // [R16] [R17]

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  always_comb begin
    done_nxt     = req & ~done_r;
    rdata_nxt    = rdata_r;
    brk_exit_nxt = brk_exit_r;
    brk_ctl_nxt  = brk_ctl_r;
    option_nxt   = option_r;
    imask_nxt    = imask_r;
    ists_nxt     = ists_r;
    cause_nxt    = cause_r;

    // Read data latched in the wait cycle, so it shows the pre-clear value
    if (avs_read && !done_r) begin
      rdata_nxt = 32'h0000_0000;
      case (avs_address) // [R08]
        sru_pkg::IDX_BREAK_EXIT:    rdata_nxt[7:0] = brk_exit_r;
        sru_pkg::IDX_RESET_CAUSE:   rdata_nxt[7:0] = cause_r; // [R18]
        sru_pkg::IDX_BREAK_CLR_CTL: rdata_nxt[7:0] = brk_ctl_r;
        sru_pkg::IDX_OPTION:        rdata_nxt[7:0] = option_r;
        sru_pkg::IDX_IRQ_STATUS:    rdata_nxt[sru_pkg::NUM_EVENTS-1:0] = ists_r;
        sru_pkg::IDX_IRQ_MASK:      rdata_nxt[sru_pkg::NUM_EVENTS-1:0] = imask_r;
        default:                    rdata_nxt = 32'h0000_0000;
      endcase
    end

    // Writes land on the accepting edge
    if (wr_acc) begin
      case (avs_address) // [R08]
        sru_pkg::IDX_BREAK_EXIT: begin
          // Software may only clear the flag by writing zero
          if (!avs_writedata[sru_pkg::BIT_BREAK_WAIT_EXIT]) begin
            brk_exit_nxt[sru_pkg::BIT_BREAK_WAIT_EXIT] = 1'b0;
          end
        end
        sru_pkg::IDX_BREAK_CLR_CTL: begin
          brk_ctl_nxt[sru_pkg::BIT_BREAK_CLR_EN] =
            avs_writedata[sru_pkg::BIT_BREAK_CLR_EN]; // [R16]
        end
        sru_pkg::IDX_OPTION: begin
          // Fast recovery with a crystal is the integrator's call
          option_nxt[sru_pkg::BIT_FAST_RECOVERY] = avs_writedata[sru_pkg::BIT_FAST_RECOVERY];
          option_nxt[sru_pkg::BIT_OSC_IN_STOP]   = avs_writedata[sru_pkg::BIT_OSC_IN_STOP];
        end
        sru_pkg::IDX_IRQ_STATUS: begin
          ists_nxt = ists_r & ~avs_writedata[sru_pkg::NUM_EVENTS-1:0];
        end
        sru_pkg::IDX_IRQ_MASK: begin
          imask_nxt = avs_writedata[sru_pkg::NUM_EVENTS-1:0];
        end
        default: begin
          imask_nxt = imask_r;
        end
      endcase
    end

    // Clear on read, then new causes on top so one arriving in the accepting cycle is kept
    if (rd_acc && avs_address == sru_pkg::IDX_RESET_CAUSE) begin
      cause_nxt = 8'h00; // [R11] [R18]
    end
    cause_nxt = cause_nxt | cause_set; // [R13]

    // Break flag: set by a break ending wait in emulation mode, cleared by an interrupt or reset wake
    if (in_wait_r && emulation_mode && break_irq) begin
      brk_exit_nxt[sru_pkg::BIT_BREAK_WAIT_EXIT] = 1'b1; // [R09] [R10]
    end else if (in_wait_r && (module_irq || any_reset_evt)) begin
      brk_exit_nxt[sru_pkg::BIT_BREAK_WAIT_EXIT] = 1'b0; // [R10]
    end

    // Event set wins over a same-cycle write-one clear
    ists_nxt = ists_nxt | ev;
  end

  assign irq = |(ists_r & imask_r);

  ////////////////////////////////////////////////////////////////////////////
  // Flops; power-on reset leaves only the power-on cause flag set

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r    <= sru_pkg::SRU_RUN;
      cnt_r      <= '0;
      in_wait_r  <= 1'b0;
      brk_exit_r <= sru_pkg::RST_BREAK_EXIT;
      cause_r    <= sru_pkg::RST_RESET_CAUSE; // [R12]
      brk_ctl_r  <= sru_pkg::RST_BREAK_CTL;
      option_r   <= sru_pkg::RST_OPTION;
      ists_r     <= sru_pkg::RST_IRQ;
      imask_r    <= sru_pkg::RST_IRQ;
      done_r     <= 1'b0;
      rdata_r    <= 32'h0000_0000;
      stack_r    <= 1'b0;
      wake_r     <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      cnt_r      <= cnt_nxt;
      in_wait_r  <= in_wait_nxt;
      brk_exit_r <= brk_exit_nxt;
      cause_r    <= cause_nxt;
      brk_ctl_r  <= brk_ctl_nxt;
      option_r   <= option_nxt;
      ists_r     <= ists_nxt;
      imask_r    <= imask_nxt;
      done_r     <= done_nxt;
      rdata_r    <= rdata_nxt;
      stack_r    <= stack_nxt;
      wake_r     <= wake_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  // Helper: cycles spent in recovery
  logic [sru_pkg::RECOVERY_CNT_W:0] rec_len_r;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rec_len_r <= '0;
    end else if (state_r == sru_pkg::SRU_RECOVER) begin
      rec_len_r <= rec_len_r + 1'b1;
    end else begin
      rec_len_r <= '0;
    end
  end

  property p_stop_entry;
    @(posedge clk) disable iff (rst)
    (state_r == sru_pkg::SRU_RUN && stop_req && !any_reset_evt)
      |=> (state_r == sru_pkg::SRU_STOPPED) && (cnt_r == '0);
  endproperty
  a_stop_entry: assert property (p_stop_entry) else $error("stop entry missed"); // [R01]

  property p_stack_delay;
    @(posedge clk) disable iff (rst)
    $rose(stack_r) |-> ($past(rec_len_r) + 1'b1 ==
      ($past(option_r[sru_pkg::BIT_FAST_RECOVERY]) ? FAST_CYC : SLOW_CYC));
  endproperty
  a_stack_delay: assert property (p_stack_delay) else $error("recovery length wrong"); // [R05]

  property p_wake_irq;
    @(posedge clk) disable iff (rst)
    (state_r == sru_pkg::SRU_STOPPED && module_irq && !any_reset_evt)
      |=> (state_r == sru_pkg::SRU_RECOVER) && !stack_r;
  endproperty
  a_wake_irq: assert property (p_wake_irq) else $error("irq did not start recovery"); // [R02]

  property p_reset_exit;
    @(posedge clk) disable iff (rst)
    (stop_active && any_reset_evt) |=> !stop_active && !stack_r;
  endproperty
  a_reset_exit: assert property (p_reset_exit) else $error("reset left stop active"); // [R03]

  property p_gate_off;
    @(posedge clk) disable iff (rst)
    stop_active |-> !clockgen_bus_output_en && !clockgen_crystal_clock_en;
  endproperty
  a_gate_off: assert property (p_gate_off) else $error("clock not gated in stop"); // [R04]

  property p_cnt_held;
    @(posedge clk) disable iff (rst)
    (state_r == sru_pkg::SRU_STOPPED) |-> (cnt_r == '0);
  endproperty
  a_cnt_held: assert property (p_cnt_held) else $error("counter moved in stop"); // [R07]

  property p_rc_read;
    @(posedge clk) disable iff (rst)
    (rd_acc && avs_address == sru_pkg::IDX_RESET_CAUSE && !any_reset_evt)
      |-> (avs_readdata[7:0] == cause_r) ##1 (cause_r == 8'h00);
  endproperty
  a_rc_read: assert property (p_rc_read) else $error("cause read or clear wrong"); // [R11]

  property p_cause_set;
    @(posedge clk) disable iff (rst)
    watchdog_evt |=> cause_r[sru_pkg::BIT_WATCHDOG]
                     && (cause_r[sru_pkg::BIT_POWER_ON] == $past(cause_r[sru_pkg::BIT_POWER_ON])
                         || $past(rd_acc));
  endproperty
  a_cause_set: assert property (p_cause_set) else $error("watchdog cause not kept"); // [R13]

  property p_brk_flag;
    @(posedge clk) disable iff (rst)
    (in_wait_r && emulation_mode && break_irq)
      |=> brk_exit_r[sru_pkg::BIT_BREAK_WAIT_EXIT] && wake_r;
  endproperty
  a_brk_flag: assert property (p_brk_flag) else $error("break exit flag not set"); // [R10]

  property p_clr_gate;
    @(posedge clk) disable iff (rst)
    (break_state && !brk_ctl_r[sru_pkg::BIT_BREAK_CLR_EN]) |-> !status_clear_allowed;
  endproperty
  a_clr_gate: assert property (p_clr_gate) else $error("clear allowed in break"); // [R16]

  property p_irq_out;
    @(posedge clk) disable iff (rst)
    ev[sru_pkg::BIT_EV_STOP_ENTER] && imask_r[sru_pkg::BIT_EV_STOP_ENTER]
      && !(wr_acc && avs_address == sru_pkg::IDX_IRQ_MASK) |=> irq;
  endproperty
  a_irq_out: assert property (p_irq_out) else $error("interrupt not raised");

endmodule : sru_system_integration_unit

// ### verification/sru_cpu_model.sv
`timescale 1ns/100ps
module sru_cpu_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       sleep,
  input  wire logic [7:0] dly,
  output logic            module_irq
);
  logic [7:0] cnt_r;
  logic       done_r;
  ////////////////////////////////////////////////////////////////////////////////
  // One wake request per sleep, so a long recovery is never cut short
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_r      <= 8'h00;
      done_r     <= 1'b0;
      module_irq <= 1'b0;
    end else begin
      module_irq <= 1'b0;
      if (!sleep) begin
        cnt_r  <= 8'h00;
        done_r <= 1'b0;
      end else if (!done_r) begin
        cnt_r <= cnt_r + 8'h01;
        if (cnt_r == dly) begin
          module_irq <= 1'b1;
          done_r     <= 1'b1;
        end
      end
    end
  end
endmodule : sru_cpu_model

// ### verification/stop_recovery_reset_status_tb_top.sv
`timescale 1ns/100ps
module stop_recovery_reset_status_tb_top;
  localparam int SLOW = 64;
  logic        clk, rst, rd, wr, stop_req, wait_req, break_irq, emu, brk, vff, tlv, wsleep;
  logic [5:0]  evs;
  logic [15:0] addr;
  logic [31:0] wdata, rdata, q;
  logic        waitreq, bus_en, xtal_en, stop_act, hold, stack, wwake, clr_ok, irq, mod_irq;
  logic [7:0]  dly;
  int          bad_count, checks, n;
  int          cbit [5] = '{sru_pkg::BIT_PIN_CAUSE, sru_pkg::BIT_WATCHDOG,
                            sru_pkg::BIT_BAD_OPCODE, sru_pkg::BIT_BAD_FETCH,
                            sru_pkg::BIT_LOW_VOLTAGE};
  ////////////////////////////////////////////////////////////////////////////////
  sru_system_integration_unit #(.SLOW_CYC(SLOW), .FAST_CYC(32)) u_sru_system_integration_unit (
    .clk(clk), .rst(rst), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(waitreq),
    .stop_req(stop_req), .wait_req(wait_req), .module_irq(mod_irq), .break_irq(break_irq),
    .emulation_mode(emu), .break_state(brk), .pin_reset_evt(evs[0]), .watchdog_evt(evs[1]),
    .bad_opcode_evt(evs[2]), .bad_fetch_evt(evs[3]), .low_voltage_evt(evs[4]),
    .monitor_entry_evt(evs[5]), .vectors_read_ff(vff), .test_level_voltage(tlv),
    .clockgen_bus_output_en(bus_en), .clockgen_crystal_clock_en(xtal_en),
    .stop_active(stop_act), .counter_hold(hold), .stacking_start(stack),
    .wait_wake(wwake), .status_clear_allowed(clr_ok), .irq(irq));
  sru_cpu_model u_sru_cpu_model (
    .clk(clk), .rst(rst), .sleep(stop_act | wsleep), .dly(dly), .module_irq(mod_irq));
  ////////////////////////////////////////////////////////////////////////////////
  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  // Bus cycle held until waitrequest is sampled low; bounded so a hang ends the run
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    int k;
    k = 0;
    @(posedge clk);
    rd    <= !w;
    wr    <= w;
    addr  <= a;
    wdata <= {24'h000000, d};
    do begin
      @(posedge clk);
      k++;
    end while (waitreq !== 1'b0 && k < 20);
    if (waitreq !== 1'b0) begin
      bad_count++;
      report_and_stop();
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic rchk(input logic [15:0] a, input logic [7:0] e, input string m);
    bus(1'b0, a, 8'h00);
    chk(q, {24'h000000, e}, m);
  endtask : rchk
  task automatic ev(input logic [5:0] m);
    @(posedge clk);
    evs <= m;
    @(posedge clk);
    evs <= 6'h00;
  endtask : ev
  // Counts edges until s shows v; running out of the bound ends the run
  task automatic wait_on(ref logic s, input logic v, input int lim, output int c);
    c = 0;
    while (s !== v && c < lim) begin
      @(posedge clk);
      #1;
      c++;
    end
    if (s !== v) begin
      bad_count++;
      report_and_stop();
    end
  endtask : wait_on
  ////////////////////////////////////////////////////////////////////////////////
  // Reset values, read-clear, unmapped index
  task automatic t_reset_regs();
    rchk(sru_pkg::IDX_RESET_CAUSE, 8'h80, "por cause");
    rchk(sru_pkg::IDX_RESET_CAUSE, 8'h00, "cause cleared");
    rchk(sru_pkg::IDX_BREAK_EXIT, 8'h00, "break status");
    rchk(sru_pkg::IDX_BREAK_CLR_CTL, 8'h00, "clr ctl");
    rchk(16'hFE02, 8'h00, "unmapped");
  endtask : t_reset_regs
  // Each cause alone, two accumulated, monitor entry gated by test level
  task automatic t_causes();
    for (int i = 0; i < 5; i++) begin
      ev(6'(1 << i));
      rchk(sru_pkg::IDX_RESET_CAUSE, 8'(1 << cbit[i]), "one cause");
      rchk(sru_pkg::IDX_RESET_CAUSE, 8'h00, "cleared");
    end
    ev(6'h01);
    ev(6'h02);
    rchk(sru_pkg::IDX_RESET_CAUSE, 8'h60, "two causes");
    vff <= 1'b1;
    tlv <= 1'b1;
    ev(6'h20);
    rchk(sru_pkg::IDX_RESET_CAUSE, 8'h00, "monitor at test level");
    tlv <= 1'b0;
    ev(6'h20);
    rchk(sru_pkg::IDX_RESET_CAUSE, 8'h04, "monitor cause");
  endtask : t_causes
  // Stop entry, wake by interrupt, recovery length counted
  task automatic t_stop(input logic fast, input int cyc);
    bus(1'b1, sru_pkg::IDX_OPTION, fast ? 8'h03 : 8'h00);
    dly <= 8'd5;
    @(posedge clk);
    stop_req <= 1'b1;
    @(posedge clk);
    stop_req <= 1'b0;
    #1;
    chk({stop_act, hold, bus_en, xtal_en}, 4'hC, "stop entry");
    wait_on(hold, 1'b0, 50, n);
    chk({stop_act, bus_en, xtal_en, stack}, 4'h8, "recovery gated");
    wait_on(stack, 1'b1, 5000, n);
    chk(n, cyc, "recovery cycles");
    chk({stop_act, bus_en, xtal_en}, 3'h3, "run again");
  endtask : t_stop
  // Reset event in stop leaves stop without stacking
  task automatic t_stop_rst();
    dly <= 8'd200;
    @(posedge clk);
    stop_req <= 1'b1;
    @(posedge clk);
    stop_req <= 1'b0;
    ev(6'h02);
    @(posedge clk);
    #1;
    chk({stop_act, stack, bus_en}, 3'h1, "reset exits stop");
    rchk(sru_pkg::IDX_RESET_CAUSE, 8'h20, "watchdog cause");
  endtask : t_stop_rst
  // Break ends wait sets the flag; a plain wake clears it
  task automatic t_wait_break();
    emu <= 1'b1;
    dly <= 8'd5;
    @(posedge clk);
    wait_req <= 1'b1;
    @(posedge clk);
    wait_req  <= 1'b0;
    break_irq <= 1'b1;
    @(posedge clk);
    break_irq <= 1'b0;
    // Wake pulse stands for one cycle only, so look at it right away
    #1;
    chk(wwake, 1'b1, "break wake");
    rchk(sru_pkg::IDX_BREAK_EXIT, 8'h02, "break ended wait");
    @(posedge clk);
    wait_req <= 1'b1;
    @(posedge clk);
    wait_req <= 1'b0;
    wsleep   <= 1'b1;
    wait_on(wwake, 1'b1, 20, n);
    wsleep <= 1'b0;
    rchk(sru_pkg::IDX_BREAK_EXIT, 8'h00, "irq ended wait");
  endtask : t_wait_break
  // Clear enable in and out of break state
  task automatic t_break_flag_clear_enable();
    brk <= 1'b1;
    bus(1'b1, sru_pkg::IDX_BREAK_CLR_CTL, 8'h80);
    rchk(sru_pkg::IDX_BREAK_CLR_CTL, 8'h80, "enable set");
    chk(clr_ok, 1'b1, "clear allowed");
    ev(6'h01);
    rchk(sru_pkg::IDX_RESET_CAUSE, 8'h40, "pin cause in break");
    bus(1'b1, sru_pkg::IDX_BREAK_CLR_CTL, 8'h00);
    @(posedge clk);
    #1;
    chk(clr_ok, 1'b0, "clear blocked");
    // Inputs only move on a rising edge
    @(posedge clk);
    brk <= 1'b0;
    rchk(sru_pkg::IDX_RESET_CAUSE, 8'h00, "stays cleared");
    chk(clr_ok, 1'b1, "outside break");
  endtask : t_break_flag_clear_enable
  // Power-on reset in mid-run wipes every other cause flag
  task automatic t_por();
    ev(6'h03);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rchk(sru_pkg::IDX_RESET_CAUSE, 8'h80, "por clears others");
    rchk(sru_pkg::IDX_IRQ_MASK, 8'h00, "mask after por");
  endtask : t_por
  // Sticky event, masked, unmasked, cleared by writing one
  task automatic t_irq();
    bus(1'b1, sru_pkg::IDX_IRQ_MASK, 8'h00);
    bus(1'b1, sru_pkg::IDX_IRQ_STATUS, 8'h0F);
    ev(6'h04);
    rchk(sru_pkg::IDX_IRQ_STATUS, 8'h04, "reset event status");
    chk(irq, 1'b0, "masked");
    bus(1'b1, sru_pkg::IDX_IRQ_MASK, 8'h04);
    @(posedge clk);
    #1;
    chk(irq, 1'b1, "unmasked");
    bus(1'b1, sru_pkg::IDX_IRQ_STATUS, 8'h04);
    @(posedge clk);
    #1;
    chk(irq, 1'b0, "cleared");
    rchk(sru_pkg::IDX_RESET_CAUSE, 8'h10, "bad opcode cause");
  endtask : t_irq
  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {rst, rd, wr, stop_req, wait_req, break_irq, emu, brk, vff, tlv, wsleep} = 11'h400;
    evs       = 6'h00;
    addr      = 16'h0000;
    wdata     = 32'h00000000;
    dly       = 8'd5;
    bad_count = 0;
    checks    = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    t_reset_regs();
    t_causes();
    t_stop(1'b0, SLOW);
    t_stop(1'b1, 32);
    t_stop_rst();
    t_wait_break();
    t_break_flag_clear_enable();
    t_irq();
    t_por();
    report_and_stop();
  end
endmodule : stop_recovery_reset_status_tb_top
